// >>> core/ssr_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defines.svh"

module ssr_status_regs
	import ssr_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = `SSR_WRITE_CYCLES
)
(
	// System clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Serial link
	input  wire logic sck,
	input  wire logic cs_b,
	input  wire logic sdi,
	output logic      sdo,
	output logic      sdo_oe,
	// Pins
	input  wire logic wp_b,
	input  wire logic wake_pin,
	// Power state
	output logic      busy,
	output logic      deep_sleep,
	output logic      low_power_standby,
	output logic      power_down_mode,
	output logic      osc_slow
);

	////////////////////////////////////////////////////////////////////////////
	// Link side, clocked by sck; shifter and output cleared between frames by cs_b

	logic [5:0]  bit_cnt_q;
	logic [6:0]  shift_q;
	logic [7:0]  op_q;
	logic [7:0]  data_q;
	logic        tog_q;
	logic [7:0]  new_byte;
	logic [7:0]  op_now;
	logic [5:0]  cnt_nx;
	logic        commit;
	logic [9:0]  stat_k;
	logic [15:0] word_k;
	logic [7:0]  cmd_k_q;

	// Status state, declared ahead of the link logic that reads it
	ssr_wr_state_t st_q;
	logic [15:0]   tmr_q;
	logic          busy_q;
	logic          auto_kind_q;
	logic          done;
	logic          latch_q;
	logic          bp_lo_q;
	logic          bp_hi_q;
	logic          lp_stby_q;
	logic          auto_pd_q;
	logic          guard_q;
	logic          auto_sleep_q;
	logic          slow_q;
	logic          deep_q;
	logic          pd_q;
	logic          osc_q;
	logic [7:0]    byte_one;
	logic          start_arr;
	logic          start_st1;
	logic          wr_ok;

	function automatic logic [5:0] cmd_len(input logic [7:0] op);
		case (op)
			`SSR_OP_WR_ENABLE, `SSR_OP_WRDI, `SSR_OP_CERS, `SSR_OP_CERS_ALT,
			`SSR_OP_PD, `SSR_OP_DEEP_SLEEP, `SSR_OP_RES: cmd_len = `SSR_LEN_OPCODE;
			`SSR_OP_WR_STAT_ONE, `SSR_OP_WR_STAT_TWO: cmd_len = `SSR_LEN_ONE_DATA;
			`SSR_OP_PERS:                          cmd_len = `SSR_LEN_ADDR;
			`SSR_OP_WR:                            cmd_len = `SSR_LEN_ADDR_DATA;
			default:                               cmd_len = `SSR_LEN_NONE;
		endcase
	endfunction : cmd_len

	// Commit decode; the count wraps to an even byte so reads keep alternating
	always_comb
	begin
		new_byte = {shift_q, sdi};
		op_now   = (bit_cnt_q == `SSR_LEN_OPCODE - 6'd1) ? new_byte : op_q;
		cnt_nx   = (bit_cnt_q == `SSR_CNT_TOP) ? `SSR_CNT_WRAP : bit_cnt_q + 6'd1;
		commit   = (cmd_len(op_now) == cnt_nx) && (bit_cnt_q < `SSR_LEN_ADDR_DATA);
	end

	// Frame shifter, cleared whenever chip select is high
	always_ff @(posedge sck or posedge cs_b)
	begin
		if (cs_b)
		begin
			bit_cnt_q <= 6'h00;
			shift_q   <= 7'h00;
			op_q      <= 8'h00;
		end
		else
		begin
			bit_cnt_q <= cnt_nx;
			shift_q   <= new_byte[6:0];
			if (bit_cnt_q == `SSR_LEN_OPCODE - 6'd1)
				op_q <= new_byte;
		end
	end

	// Finished command: opcode and data held here, since chip select clears the shifter
	// before the toggle reaches the system clock
	always_ff @(posedge sck or negedge rst_b)
	begin
		if (!rst_b)
		begin
			data_q  <= 8'h00;
			cmd_k_q <= 8'h00;
			tog_q   <= 1'b0;
		end
		else if (commit)
		begin
			data_q  <= new_byte;
			cmd_k_q <= op_now;
			tog_q   <= ~tog_q;
		end
	end

	// Status bits into the link domain; each bit is an independent flag
	ssr_sync #(.WIDTH(10)) u_sync_link
	(
		.clk   (sck),
		.rst_b (1'b1),
		.d     ({slow_q, auto_sleep_q, byte_one}),
		.q     (stat_k)
	);

	assign word_k = {`SSR_B2_RSVD, stat_k};

	// read while busy
	// Output on falling edge; byte one, byte two, repeating; released in deep sleep
	always_ff @(negedge sck or posedge cs_b)
	begin
		if (cs_b)
		begin
			sdo    <= 1'b0;
			sdo_oe <= 1'b0;
		end
		else
		begin
			sdo    <= word_k[{~bit_cnt_q[3], ~bit_cnt_q[2:0]}];
			sdo_oe <= (op_q == `SSR_OP_RDSR) && !stat_k[`SSR_B1_DEEP];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// System side: crossings and command capture

	logic [3:0]    pins_s;
	logic          tog_s;
	logic          cs_s;
	logic          wp_s;
	logic          wake_s;
	logic          tog_seen_q;
	logic          cs_prev_q;
	logic          wake_prev_q;
	logic          pend_q;
	logic [7:0]    cmd_c_q;
	logic [7:0]    dat_c_q;
	logic          tog_edge;
	logic          exec_v;
	logic [7:0]    exec_op;
	logic [7:0]    exec_dat;
	logic          take;
	logic          guard_act;

	ssr_sync #(.WIDTH(4)) u_sync_sys
	(
		.clk   (clk),
		.rst_b (rst_b),
		.d     ({wake_pin, wp_b, cs_b, tog_q}),
		.q     (pins_s)
	);

	assign {wake_s, wp_s, cs_s, tog_s} = pins_s;
	assign tog_edge = tog_s != tog_seen_q;

	// Commands act only once the frame has ended
	assign exec_v   = cs_s && !cs_prev_q && (pend_q || tog_edge);
	assign exec_op  = tog_edge ? cmd_k_q : cmd_c_q;
	assign exec_dat = tog_edge ? data_q : dat_c_q;
	// Deep sleep ignores all; power down only answers resume; busy ignores all
	assign take     = exec_v && !deep_q && !busy_q && (!pd_q || exec_op == `SSR_OP_RES);

	// guard needs pin low and bit set
	assign guard_act = !wp_s && guard_q;

	// Capture a finished command until the frame end is seen
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			tog_seen_q  <= 1'b0;
			cs_prev_q   <= 1'b0;
			wake_prev_q <= 1'b0;
			pend_q      <= 1'b0;
			cmd_c_q     <= 8'h00;
			dat_c_q     <= 8'h00;
		end
		else
		begin
			cs_prev_q   <= cs_s;
			wake_prev_q <= wake_s;
			if (tog_edge)
			begin
				tog_seen_q <= tog_s;
				cmd_c_q    <= cmd_k_q;
				dat_c_q    <= data_q;
			end
			pend_q <= exec_v ? 1'b0 : (pend_q || tog_edge);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status state

	assign wr_ok     = take && latch_q && (exec_op == `SSR_OP_WR_STAT_ONE || exec_op == `SSR_OP_WR_STAT_TWO
	                   || exec_op == `SSR_OP_WR || exec_op == `SSR_OP_PERS
	                   || exec_op == `SSR_OP_CERS || exec_op == `SSR_OP_CERS_ALT);
	assign start_st1 = wr_ok && exec_op == `SSR_OP_WR_STAT_ONE && !guard_act;
	assign start_arr = wr_ok && exec_op != `SSR_OP_WR_STAT_ONE && exec_op != `SSR_OP_WR_STAT_TWO;
	assign done      = busy_q && !osc_q && tmr_q == 16'(WRITE_CYCLES - 1);

	assign byte_one = {guard_q, auto_pd_q, lp_stby_q, deep_q, bp_hi_q, bp_lo_q, latch_q, busy_q};

	// slowed oscillator halves the timer rate
	// Self-timed write engine
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			st_q        <= SSR_IDLE;
			tmr_q       <= 16'h0000;
			auto_kind_q <= 1'b0;
			osc_q       <= 1'b0;
		end
		else
		begin
			osc_q <= busy_q && slow_q && !osc_q;
			case (st_q)
				SSR_IDLE:
				begin
					tmr_q <= 16'h0000;
					if (start_st1 || start_arr)
					begin
						st_q        <= SSR_BUSY;
						auto_kind_q <= 1'b1;
					end
				end
				SSR_BUSY:
				begin
					if (done)
						st_q <= SSR_IDLE;
					else if (!osc_q)
						tmr_q <= tmr_q + 16'h0001;
				end
				default:
					st_q <= SSR_IDLE;
			endcase
		end
	end

	assign busy_q = st_q == SSR_BUSY;

	// latch set and cleared by commands
	// latch cleared when a write completes
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			latch_q <= 1'b0;
		else if (done || (wr_ok && exec_op == `SSR_OP_WR_STAT_TWO))
			latch_q <= 1'b0;
		else if (take && exec_op == `SSR_OP_WR_ENABLE)
			latch_q <= 1'b1;
		else if (take && exec_op == `SSR_OP_WRDI)
			latch_q <= 1'b0;
	end

	// flag bits of the data byte dropped
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			{guard_q, auto_pd_q, lp_stby_q, bp_hi_q, bp_lo_q} <= `SSR_B1_CFG_RST;
		else if (start_st1)
		begin
			bp_lo_q <= exec_dat[`SSR_B1_BP_LO];
			bp_hi_q <= exec_dat[`SSR_B1_BP_HI];
			lp_stby_q <= exec_dat[`SSR_B1_LP_STBY];
			auto_pd_q <= exec_dat[`SSR_B1_AUTO_PD];
			guard_q <= exec_dat[`SSR_B1_GUARD];
		end
	end

	// byte two volatile, reset clears it
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			{slow_q, auto_sleep_q} <= `SSR_B2_CFG_RST;
		else if (wr_ok && exec_op == `SSR_OP_WR_STAT_TWO && !guard_act)
		begin
			auto_sleep_q <= exec_dat[`SSR_B2_AUTO_SLEEP];
			slow_q  <= exec_dat[`SSR_B2_SLOW];
		end
	end

	// only timed writes trigger; byte two is untimed
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			deep_q <= 1'b0;
			pd_q   <= 1'b0;
		end
		else
		begin
			// Entry wins over a wake edge in the same cycle, so no sleep request is lost
			if ((done && auto_kind_q && auto_sleep_q) || (take && exec_op == `SSR_OP_DEEP_SLEEP))
				deep_q <= 1'b1;
			else if (wake_s && !wake_prev_q)
				deep_q <= 1'b0;
			if (take && exec_op == `SSR_OP_PD)
				pd_q <= 1'b1;
			else if (take && exec_op == `SSR_OP_RES)
				pd_q <= 1'b0;
		end
	end

	// Power outputs; idle means frame closed and no write running
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			busy              <= 1'b0;
			deep_sleep        <= 1'b0;
			low_power_standby <= 1'b0;
			power_down_mode   <= 1'b0;
			osc_slow          <= 1'b0;
		end
		else
		begin
			busy              <= busy_q;
			deep_sleep        <= deep_q;
			low_power_standby <= cs_s && !busy_q && lp_stby_q && !deep_q && !pd_q;
			power_down_mode   <= !deep_q && (pd_q || (cs_s && !busy_q && auto_pd_q));
			osc_slow          <= osc_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_latch_clear_end: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(busy_q) |-> !latch_q)
		else $error("latch still set after write");

	a_start_needs_latch: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(busy_q) |-> $past(latch_q))
		else $error("write started without latch");

	a_nowel_keeps_cfg: assert property (@(posedge clk) disable iff (!rst_b)
		(exec_v && exec_op == `SSR_OP_WR_STAT_ONE && !latch_q) |=> $stable({bp_hi_q, bp_lo_q, guard_q}))
		else $error("config changed without latch");

	a_guard_blocks: assert property (@(posedge clk) disable iff (!rst_b)
		(exec_v && exec_op == `SSR_OP_WR_STAT_ONE && guard_act) |=> $stable(byte_one[7:2]) && !busy_q)
		else $error("guarded status written");

	a_auto_sleep: assert property (@(posedge clk) disable iff (!rst_b)
		($fell(busy_q) && auto_sleep_q && !$past(wake_s)) |-> deep_q)
		else $error("no sleep after write");

	a_b2_no_sleep: assert property (@(posedge clk) disable iff (!rst_b)
		(take && exec_op == `SSR_OP_WR_STAT_TWO) |=> !deep_q && !busy_q)
		else $error("byte two write caused sleep");

	a_enable_sets: assert property (@(posedge clk) disable iff (!rst_b)
		(take && exec_op == `SSR_OP_WR_ENABLE) |=> latch_q [*2])
		else $error("latch not set");

	a_busy_length: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(busy_q) |-> busy_q [*8])
		else $error("write ended early");

	a_deep_ignores: assert property (@(posedge clk) disable iff (!rst_b)
		(deep_q && exec_v) |=> $stable(latch_q) && !busy_q)
		else $error("command taken in deep sleep");

endmodule : ssr_status_regs

`default_nettype wire

// >>> core/ssr_defines.svh
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

// Opcodes seen on the serial link
`define SSR_OP_WR_STAT_ONE 8'h01
`define SSR_OP_WR          8'h02
`define SSR_OP_WRDI        8'h04
`define SSR_OP_RDSR        8'h05
`define SSR_OP_WR_ENABLE   8'h06
`define SSR_OP_PERS        8'h42
`define SSR_OP_CERS        8'h60
`define SSR_OP_CERS_ALT    8'hc7
`define SSR_OP_WR_STAT_TWO 8'h31
`define SSR_OP_PD          8'hb9
`define SSR_OP_DEEP_SLEEP  8'h79
`define SSR_OP_RES         8'hab

// Link bit counts at which a command is complete, and the counter top and wrap point
`define SSR_LEN_NONE       6'd0
`define SSR_LEN_OPCODE     6'd8
`define SSR_LEN_ONE_DATA   6'd16
`define SSR_LEN_ADDR       6'd24
`define SSR_LEN_ADDR_DATA  6'd32
`define SSR_CNT_TOP        6'h3f
`define SSR_CNT_WRAP       6'h30

// Status byte one field positions
`define SSR_B1_BUSY        0
`define SSR_B1_LATCH       1
`define SSR_B1_BP_LO       2
`define SSR_B1_BP_HI       3
`define SSR_B1_DEEP        4
`define SSR_B1_LP_STBY     5
`define SSR_B1_AUTO_PD     6
`define SSR_B1_GUARD       7

// Status byte two field positions
`define SSR_B2_AUTO_SLEEP  0
`define SSR_B2_SLOW        1

// Reset values of stored bits
`define SSR_B1_CFG_RST     5'h00
`define SSR_B2_CFG_RST     2'h0
`define SSR_B2_RSVD        6'h00

// Self-timed write duration
`define SSR_CLK_MHZ        100
`define SSR_WRITE_TIME_US  100
`define SSR_WRITE_CYCLES   (`SSR_WRITE_TIME_US * `SSR_CLK_MHZ)

`endif

// >>> core/ssr_pkg.sv
package ssr_pkg;

	// Self-timed write engine
	typedef enum logic [1:0]
	{
		SSR_IDLE = 2'b01,
		SSR_BUSY = 2'b10
	} ssr_wr_state_t;

endpackage : ssr_pkg

// >>> core/ssr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ssr_sync
	import ssr_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// Data
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	// Two stages; only the second stage reads the first
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			meta_q <= '0;
			q      <= '0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : ssr_sync

`default_nettype wire

// >>> sim/ssr_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defines.svh"

// Mode 0 bus master; sck stands low outside frames
module ssr_spi_master
(
	// Link
	output logic      sck,
	output logic      cs_b,
	output logic      sdi,
	input  wire logic sdo_line
);
	logic [15:0] rd_word;
	event        rd_ev;

	// Idle bus
	initial
	begin
		sck = 1'b0;
		cs_b = 1'b1;
		sdi = 1'b0;
		rd_word = 16'h0000;
	end

	////////////////////////////////////////
	// One whole frame, MSB first; sdo sampled as sck rises
	task automatic xfer(input logic [23:0] w, input int nbits);
		cs_b = 1'b0;
		for (int i = 0; i < nbits; i++)
		begin
			sdi = w[23-i];
			#3;
			rd_word = {rd_word[14:0], sdo_line};
			sck = 1'b1;
			#3;
			sck = 1'b0;
		end
		#3;
		cs_b = 1'b1;
		// Released line must not keep its last value
		sdi = ~sdi;
		if (w[23:16] == `SSR_OP_RDSR)
			->rd_ev;
		// Gap keeps frames at least five clk apart
		#60;
	endtask : xfer
endmodule : ssr_spi_master
`default_nettype wire

// >>> sim/test_serial_eeprom_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defines.svh"

module test_serial_eeprom_status_regs;
	// Short write time keeps the run brief
	localparam int WC = 40;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        wp_b = 1'b1;
	logic        wake_pin = 1'b0;
	logic [31:0] seed = 32'h94396677;
	logic [7:0]  b1;
	logic [15:0] exq[$];
	int          n_mismatch = 0;
	int          compares = 0;
	int          cyc = 0;
	wire logic   sck, cs_b, sdi, sdo, sdo_oe, sdo_line;
	wire logic   busy, deep_sleep, lps, pdm, osc_slow;

	// Pull-up holds the line while the device lets go
	assign sdo_line = sdo_oe ? sdo : 1'b1;

	always #5 clk = ~clk;

	ssr_status_regs #(.WRITE_CYCLES(WC)) uut
	(
		.clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .sdi(sdi), .sdo(sdo),
		.sdo_oe(sdo_oe), .wp_b(wp_b), .wake_pin(wake_pin), .busy(busy),
		.deep_sleep(deep_sleep), .low_power_standby(lps), .power_down_mode(pdm),
		.osc_slow(osc_slow)
	);

	ssr_spi_master m
	(
		.sck(sck), .cs_b(cs_b), .sdi(sdi), .sdo_line(sdo_line)
	);

	////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	// Cycle ceiling cuts a hang short
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end

	// Each status read against the oldest note; polls leave none
	always @(m.rd_ev)
	begin
		#1;
		if (exq.size() > 0)
			check("status", m.rd_word, exq.pop_front());
	end

	////////////////////////////////////////
	task automatic rd(input logic [15:0] exp);
		exq.push_back(exp);
		m.xfer({`SSR_OP_RDSR, 16'h0000}, 24);
	endtask : rd

	task automatic wr(input logic [7:0] op, input logic [7:0] d);
		m.xfer({`SSR_OP_WR_ENABLE, 16'h0000}, 8);
		m.xfer({op, d, 8'h00}, 16);
	endtask : wr

	// Busy length and any slowed phase of the write
	task automatic settle(input int lo, input int hi, input logic slow);
		int   n;
		logic seen;
		n = 0;
		seen = 1'b0;
		while (busy === 1'b1 && n < 200)
		begin
			@(negedge clk);
			seen |= osc_slow;
			n++;
		end
		repeat (4) @(negedge clk);
		check("busy_len", 16'(n >= lo && n <= hi), 16'h0001);
		check("osc_slow", {15'h0, seen}, {15'h0, slow});
	endtask : settle

	////////////////////////////////////////
	initial
	begin
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		rd(16'h0000);
		m.xfer({`SSR_OP_WR_STAT_ONE, 8'h0c, 8'h00}, 16);
		rd(16'h0000);
		m.xfer({`SSR_OP_WR_ENABLE, 16'h0000}, 8);
		rd(16'h0200);
		m.xfer({`SSR_OP_WRDI, 16'h0000}, 8);
		rd(16'h0000);
		$display("test latch done");
		repeat (4)
		begin
			b1 = rnd();
			wr(`SSR_OP_WR_STAT_ONE, b1);
			b1 &= 8'hec;
			rd({b1 | 8'h03, 8'h00});
			settle(1, WC, 1'b0);
			rd({b1, 8'h00});
			check("pwr_down", {15'h0, pdm}, {15'h0, b1[6]});
			if (!b1[6])
				check("lp_stby", {15'h0, lps}, {15'h0, b1[5]});
		end
		$display("test byte one done");
		wr(`SSR_OP_WR_STAT_TWO, (rnd() & 8'hfe) | 8'h02);
		rd({b1, 8'h02});
		wr(`SSR_OP_WR_STAT_ONE, 8'h00);
		settle(2 * WC - 6, 2 * WC + 3, 1'b1);
		wr(`SSR_OP_WR_STAT_TWO, 8'h00);
		wr(`SSR_OP_WR_STAT_ONE, 8'h00);
		settle(WC - 6, WC + 2, 1'b0);
		$display("test write time done");
		// pin low and guard set lock
		wr(`SSR_OP_WR_STAT_ONE, 8'h80);
		settle(WC - 6, WC + 2, 1'b0);
		wp_b = 1'b0;
		repeat (4) @(negedge clk);
		wr(`SSR_OP_WR_STAT_ONE, 8'h0c);
		@(negedge clk);
		check("locked", {15'h0, busy}, 16'h0000);
		rd(16'h8200);
		@(negedge clk);
		wp_b = 1'b1;
		repeat (4) @(negedge clk);
		m.xfer({`SSR_OP_WR_STAT_ONE, 8'h0c, 8'h00}, 16);
		settle(WC - 6, WC + 2, 1'b0);
		rd(16'h0c00);
		$display("test guard done");
		wr(`SSR_OP_WR_STAT_TWO, 8'h01);
		@(negedge clk);
		check("no_sleep", {15'h0, deep_sleep}, 16'h0000);
		rd(16'h0c01);
		wr(`SSR_OP_WR_STAT_ONE, 8'h0c);
		settle(WC - 6, WC + 2, 1'b0);
		check("sleep", {15'h0, deep_sleep}, 16'h0001);
		rd(16'hffff);
		@(negedge clk);
		wake_pin = 1'b1;
		repeat (4) @(negedge clk);
		wake_pin = 1'b0;
		for (int i = 0; i < 8 && m.rd_word[12] !== 1'b0; i++)
			m.xfer({`SSR_OP_RDSR, 16'h0000}, 24);
		@(negedge clk);
		check("woken", {15'h0, deep_sleep}, 16'h0000);
		$display("test deep sleep done");
		// Power down takes only resume; enable command is dropped
		m.xfer({`SSR_OP_PD, 16'h0000}, 8);
		check("pd_on", {15'h0, pdm}, 16'h0001);
		m.xfer({`SSR_OP_WR_ENABLE, 16'h0000}, 8);
		rd(16'h0c01);
		m.xfer({`SSR_OP_RES, 16'h0000}, 8);
		@(negedge clk);
		check("pd_off", {15'h0, pdm}, 16'h0000);
		$display("test power down done");
		wrap_up();
	end
endmodule : test_serial_eeprom_status_regs
`default_nettype wire
